//--- hel_pkg.sv
package hel_pkg;

  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 32;
  localparam int          CNT_W        = 16;

  // Register map, byte addresses on APB
  localparam logic [11:0] OFS_GCTL     = 12'h000;
  localparam logic [11:0] OFS_GSTAT    = 12'h004;
  localparam logic [11:0] OFS_BANK0    = 12'h100;
  localparam logic [11:0] BANK_STRIDE  = 12'h010;
  localparam logic [11:0] OFS_CTL      = 12'h000;
  localparam logic [11:0] OFS_STAT     = 12'h004;
  localparam logic [11:0] OFS_ADDR     = 12'h008;
  localparam logic [11:0] OFS_MISC     = 12'h00C;

  // Bank control fields
  localparam int          CTL_LOG_BIT  = 0;
  localparam int          CTL_REP_BIT  = 1;
  localparam int          CTL_DIS_BIT  = 2;
  localparam logic [2:0]  CTL_RST      = 3'h3;

  // Global control and status fields
  localparam int          GCTL_DEF_BIT = 0;
  localparam int          GCTL_THR_BIT = 1;
  localparam logic [1:0]  GCTL_RST     = 2'h0;
  localparam int          GST_SHD_BIT  = 0;
  localparam int          GST_MCE_BIT  = 1;

  // Bank status fields
  localparam int          ST_CLS_LSB   = 0;
  localparam int          ST_POI_BIT   = 29;
  localparam int          ST_OVF_BIT   = 30;
  localparam int          ST_VAL_BIT   = 31;

  // Bank miscellaneous fields
  localparam int          MISC_CNT_LSB = 0;
  localparam int          MISC_THR_LSB = 16;
  localparam logic [15:0] THR_RST      = 16'h0010;

  typedef enum logic [1:0] {
    CLS_CORR   = 2'b00,
    CLS_DEFER  = 2'b01,
    CLS_UNCORR = 2'b11
  } hel_class_t;

  typedef struct packed {
    logic                strobe;
    logic                fixable;
    logic                deferrable;
    logic                fatal;
    logic [DATA_W-1:0]   actual;
    logic [DATA_W-1:0]   expected;
    logic [ADDR_W-1:0]   addr;
  } hel_src_t;

  typedef struct packed {
    logic act_dis;
    logic rep_en;
    logic log_en;
  } hel_ctl_t;

  typedef struct packed {
    logic       valid;
    logic       ovf;
    logic       poison;
    hel_class_t cls;
  } hel_stat_t;

endpackage

//--- hel_checker.sv
`timescale 1ns/1ps
`default_nettype none
module hel_checker (
  input  wire logic             src_strobe_in,  // Checked transfer present
  input  wire logic [7:0]       actual_in,      // Observed outcome
  input  wire logic [7:0]       expected_in,    // Predicted outcome
  output var  logic             mismatch_out    // Error detected this cycle
);

  always_comb begin
    mismatch_out = src_strobe_in && (actual_in != expected_in);
  end

endmodule
`default_nettype wire

//--- hel_top.sv
// What this block does
// - Compare actual against expected outcome of each check; flag any difference.
// - On an error, hardware corrects or contains it without software.
// - Per-bank control bit disables the autonomous correct or contain action.
// - Enabled bank records the detected error in its logging registers.
// - Disabled bank drops the error information.
// - Uncorrected error raises machine check only when reporting is enabled.
// - Each source has a software reporting enable for machine check.
// - Reporting disabled does not stop logging.
// - Every error gets one class: corrected, deferred or uncorrected.
// - Corrected errors raise no exception, only logged when enabled.
// - An error hardware can neither correct nor defer is classed uncorrected.
// - Deferred errors are logged if enabled but raise no machine check.
// - Deferred errors are tracked and become uncorrected when about to be used.
// - That reclassification raises machine check if reporting is enabled.
// - Unconsumed uncorrectable data is tagged poison instead of reported.
// - Consuming poisoned data reports a localized machine check.
// - Uncontainable error forces the core into shutdown.
// - Optional interrupt fires when a deferred error is first detected.
// - Corrected errors are counted in banks with logging enabled; passing a threshold raises an interrupt.
// - Both interrupts are independent of machine check enables.
// - Logged information survives warm reset; only cold reset clears it.
// - Each bank has control, status, address and misc registers.
`timescale 1ns/1ps
`default_nettype none
module hel_top #(
  parameter int N_BANK = 4
) (
  input  wire logic                   clock_in,        // Core clock
  input  wire logic                   rst_in,          // Warm reset
  input  wire logic                   cold_rst_in,     // Cold power-up reset
  input  wire hel_pkg::hel_src_t      src_in [N_BANK], // Error source reports
  input  wire logic [N_BANK-1:0]      consume_in,      // Data about to be used
  input  wire logic [11:0]            paddr_in,        // APB address
  input  wire logic                   psel_in,         // APB select
  input  wire logic                   penable_in,      // APB enable
  input  wire logic                   pwrite_in,       // APB direction
  input  wire logic [31:0]            pwdata_in,       // APB write data
  output logic [31:0]                 prdata_out,      // APB read data
  output logic                        pready_out,      // APB ready
  output logic                        pslverr_out,     // APB error
  output logic                        machine_check_exception_out, // Exception pulse
  output logic                        shutdown_out,    // Core halted
  output logic                        deferred_irq_out,  // First deferred pulse
  output logic                        threshold_irq_out, // Count crossing pulse
  output logic [N_BANK-1:0]           correct_out,     // Correction action
  output logic [N_BANK-1:0]           contain_out,     // Containment action
  output logic [N_BANK-1:0]           poison_out       // Poison tag per bank
);

  localparam logic [hel_pkg::CNT_W-1:0] CNT_MAX = '1;

  hel_pkg::hel_ctl_t                ctl_r    [N_BANK];
  hel_pkg::hel_stat_t               stat_r   [N_BANK];
  hel_pkg::hel_stat_t               stat_nxt [N_BANK];
  logic [hel_pkg::ADDR_W-1:0]       addr_r   [N_BANK];
  logic [hel_pkg::ADDR_W-1:0]       addr_nxt [N_BANK];
  logic [hel_pkg::CNT_W-1:0]        cnt_r    [N_BANK];
  logic [hel_pkg::CNT_W-1:0]        cnt_nxt  [N_BANK];
  logic [hel_pkg::CNT_W-1:0]        thr_r    [N_BANK];
  logic [N_BANK-1:0]                mis;
  logic [N_BANK-1:0]                cons;
  logic [N_BANK-1:0]                rep_hit;
  logic [N_BANK-1:0]                fatal_hit;
  logic [N_BANK-1:0]                def_first;
  logic [N_BANK-1:0]                thr_cross;
  logic [N_BANK-1:0]                poison_nxt;
  hel_pkg::hel_class_t              cls      [N_BANK];
  logic [1:0]                       gctl_r;
  logic                             mce_seen_r;
  logic                             wr_en;
  logic                             acc;
  logic [31:0]                      rd_data;
  logic                             rd_ok;

  function automatic logic bank_hit(input logic [11:0] a, input int b, input logic [11:0] o);
    return a == 12'(hel_pkg::OFS_BANK0 + hel_pkg::BANK_STRIDE * b + o);
  endfunction

  function automatic hel_pkg::hel_class_t classify(input logic fixable, input logic deferrable);
    if (fixable) begin
      return hel_pkg::CLS_CORR;
    end else if (deferrable) begin
      return hel_pkg::CLS_DEFER;
    end
    return hel_pkg::CLS_UNCORR;
  endfunction

  for (genvar g = 0; g < N_BANK; g++) begin : g_chk
    hel_checker u_chk (
      .src_strobe_in (src_in[g].strobe),
      .actual_in     (src_in[g].actual),
      .expected_in   (src_in[g].expected),
      .mismatch_out  (mis[g])
    );
  end

  assign acc   = psel_in && penable_in && pready_out;
  assign wr_en = acc && pwrite_in;

  // Classification and event decode per bank
  always_comb begin
    for (int i = 0; i < N_BANK; i++) begin
      // Correction disabled leaves the error deferred if deferrable, else uncorrected
      cls[i]       = classify(src_in[i].fixable && !ctl_r[i].act_dis, src_in[i].deferrable);
      cons[i]      = consume_in[i] && poison_out[i];
      rep_hit[i]   = ctl_r[i].rep_en && ((mis[i] && cls[i] == hel_pkg::CLS_UNCORR) || cons[i]);
      fatal_hit[i] = mis[i] && src_in[i].fatal && cls[i] == hel_pkg::CLS_UNCORR;
      def_first[i] = mis[i] && cls[i] == hel_pkg::CLS_DEFER && !poison_out[i];
    end
  end

  // Logging next state; a new log wins over a software clear only when no record was valid
  always_comb begin
    for (int i = 0; i < N_BANK; i++) begin
      stat_nxt[i]   = stat_r[i];
      addr_nxt[i]   = addr_r[i];
      cnt_nxt[i]    = cnt_r[i];
      thr_cross[i]  = 1'b0;
      poison_nxt[i] = poison_out[i];
      if (cons[i]) begin
        poison_nxt[i] = 1'b0;
      end
      if (mis[i] && cls[i] == hel_pkg::CLS_DEFER) begin
        poison_nxt[i] = 1'b1;
      end
      if (wr_en && bank_hit(paddr_in, i, hel_pkg::OFS_STAT)) begin
        stat_nxt[i] = '0;
      end
      if (wr_en && bank_hit(paddr_in, i, hel_pkg::OFS_MISC)) begin
        cnt_nxt[i] = '0;
      end
      if (cons[i] && stat_r[i].valid && stat_r[i].cls == hel_pkg::CLS_DEFER) begin
        stat_nxt[i].cls = hel_pkg::CLS_UNCORR;
      end
      if (mis[i] && ctl_r[i].log_en) begin
        if (stat_r[i].valid) begin
          stat_nxt[i].ovf = 1'b1;
          // Keep the first record unless the new one is uncorrected and the first is not
          if (cls[i] == hel_pkg::CLS_UNCORR && stat_r[i].cls != hel_pkg::CLS_UNCORR) begin
            stat_nxt[i].cls = cls[i];
            addr_nxt[i]     = src_in[i].addr;
          end
        end else begin
          stat_nxt[i].valid = 1'b1;
          stat_nxt[i].ovf   = 1'b0;
          stat_nxt[i].cls   = cls[i];
          addr_nxt[i]       = src_in[i].addr;
        end
        stat_nxt[i].poison = stat_nxt[i].poison || cls[i] == hel_pkg::CLS_DEFER;
        if (cls[i] == hel_pkg::CLS_CORR) begin
          if (cnt_r[i] != CNT_MAX) begin
            cnt_nxt[i] = cnt_r[i] + 1'b1;
          end
          thr_cross[i] = (cnt_r[i] == thr_r[i]) && (cnt_r[i] != CNT_MAX);
        end
      end
    end
  end

  // Logged state: cleared by cold reset only
  always_ff @(posedge clock_in) begin
    for (int i = 0; i < N_BANK; i++) begin
      if (cold_rst_in) begin
        stat_r[i]     <= '0;
        addr_r[i]     <= '0;
        cnt_r[i]      <= '0;
        poison_out[i] <= 1'b0;
      end else begin
        stat_r[i]     <= stat_nxt[i];
        addr_r[i]     <= addr_nxt[i];
        cnt_r[i]      <= cnt_nxt[i];
        poison_out[i] <= poison_nxt[i];
      end
    end
  end

  // Bank controls and thresholds
  always_ff @(posedge clock_in) begin
    for (int i = 0; i < N_BANK; i++) begin
      if (rst_in || cold_rst_in) begin
        ctl_r[i] <= hel_pkg::CTL_RST;
        thr_r[i] <= hel_pkg::THR_RST;
      end else begin
        if (wr_en && bank_hit(paddr_in, i, hel_pkg::OFS_CTL)) begin
          ctl_r[i].log_en  <= pwdata_in[hel_pkg::CTL_LOG_BIT];
          ctl_r[i].rep_en  <= pwdata_in[hel_pkg::CTL_REP_BIT];
          ctl_r[i].act_dis <= pwdata_in[hel_pkg::CTL_DIS_BIT];
        end
        if (wr_en && bank_hit(paddr_in, i, hel_pkg::OFS_MISC)) begin
          thr_r[i] <= pwdata_in[hel_pkg::MISC_THR_LSB +: hel_pkg::CNT_W];
        end
      end
    end
  end

  // Global control
  always_ff @(posedge clock_in) begin
    if (rst_in || cold_rst_in) begin
      gctl_r <= hel_pkg::GCTL_RST;
    end else if (wr_en && paddr_in == hel_pkg::OFS_GCTL) begin
      gctl_r <= pwdata_in[1:0];
    end
  end

  // Autonomous correct and contain actions
  always_ff @(posedge clock_in) begin
    for (int i = 0; i < N_BANK; i++) begin
      if (rst_in || cold_rst_in) begin
        correct_out[i] <= 1'b0;
        contain_out[i] <= 1'b0;
      end else begin
        correct_out[i] <= mis[i] && cls[i] == hel_pkg::CLS_CORR;
        contain_out[i] <= mis[i] && cls[i] != hel_pkg::CLS_CORR && !ctl_r[i].act_dis;
      end
    end
  end

  // Machine check, shutdown and its sticky status
  always_ff @(posedge clock_in) begin
    if (rst_in || cold_rst_in) begin
      machine_check_exception_out <= 1'b0;
      shutdown_out                <= 1'b0;
      mce_seen_r                  <= 1'b0;
    end else begin
      machine_check_exception_out <= |rep_hit;
      if (|fatal_hit) begin
        shutdown_out <= 1'b1;
      end
      if (|rep_hit) begin
        mce_seen_r <= 1'b1;
      end else if (wr_en && paddr_in == hel_pkg::OFS_GSTAT) begin
        mce_seen_r <= 1'b0;
      end
    end
  end

  // Notification interrupts, independent of reporting enables
  always_ff @(posedge clock_in) begin
    if (rst_in || cold_rst_in) begin
      deferred_irq_out  <= 1'b0;
      threshold_irq_out <= 1'b0;
    end else begin
      deferred_irq_out  <= gctl_r[hel_pkg::GCTL_DEF_BIT] && (|def_first);
      threshold_irq_out <= gctl_r[hel_pkg::GCTL_THR_BIT] && (|thr_cross);
    end
  end

  // Read decode over the register map
  always_comb begin
    rd_data = '0;
    rd_ok   = 1'b0;
    if (paddr_in == hel_pkg::OFS_GCTL) begin
      rd_data[1:0] = gctl_r;
      rd_ok        = 1'b1;
    end else if (paddr_in == hel_pkg::OFS_GSTAT) begin
      rd_data[hel_pkg::GST_SHD_BIT] = shutdown_out;
      rd_data[hel_pkg::GST_MCE_BIT] = mce_seen_r;
      rd_ok                         = 1'b1;
    end
    for (int i = 0; i < N_BANK; i++) begin
      if (bank_hit(paddr_in, i, hel_pkg::OFS_CTL)) begin
        rd_data[2:0] = ctl_r[i];
        rd_ok        = 1'b1;
      end
      if (bank_hit(paddr_in, i, hel_pkg::OFS_STAT)) begin
        rd_data[hel_pkg::ST_VAL_BIT]     = stat_r[i].valid;
        rd_data[hel_pkg::ST_OVF_BIT]     = stat_r[i].ovf;
        rd_data[hel_pkg::ST_POI_BIT]     = stat_r[i].poison;
        rd_data[hel_pkg::ST_CLS_LSB +: 2] = stat_r[i].cls;
        rd_ok                            = 1'b1;
      end
      if (bank_hit(paddr_in, i, hel_pkg::OFS_ADDR)) begin
        rd_data = addr_r[i];
        rd_ok   = 1'b1;
      end
      if (bank_hit(paddr_in, i, hel_pkg::OFS_MISC)) begin
        rd_data[hel_pkg::MISC_CNT_LSB +: hel_pkg::CNT_W] = cnt_r[i];
        rd_data[hel_pkg::MISC_THR_LSB +: hel_pkg::CNT_W] = thr_r[i];
        rd_ok                                            = 1'b1;
      end
    end
  end

  // APB slave: one wait state, answer registered
  always_ff @(posedge clock_in) begin
    if (rst_in || cold_rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= '0;
    end else begin
      pready_out  <= psel_in && penable_in && !pready_out;
      pslverr_out <= psel_in && penable_in && !pready_out && !rd_ok;
      if (psel_in && penable_in && !pready_out && !pwrite_in) begin
        prdata_out <= rd_data;
      end
    end
  end

endmodule
`default_nettype wire

//--- hel_props.sv
`timescale 1ns/1ps
`default_nettype none
module hel_props #(
  parameter int N_BANK = 4
) (
  input wire logic              clock_in,                    // Core clock
  input wire logic              rst_in,                      // Warm reset
  input wire logic              cold_rst_in,                 // Cold reset
  input wire hel_pkg::hel_src_t src_in [N_BANK],             // Source reports
  input wire logic [N_BANK-1:0] consume_in,                  // Consume pulses
  input wire logic              psel_in,                     // APB select
  input wire logic              penable_in,                  // APB enable
  input wire logic              pready_out,                  // APB ready
  input wire logic              pslverr_out,                 // APB error
  input wire logic              machine_check_exception_out, // Exception pulse
  input wire logic              shutdown_out,                // Core halted
  input wire logic              deferred_irq_out,            // Deferred pulse
  input wire logic              threshold_irq_out,           // Threshold pulse
  input wire logic [N_BANK-1:0] correct_out,                 // Correction pulses
  input wire logic [N_BANK-1:0] contain_out,                 // Containment pulses
  input wire logic [N_BANK-1:0] poison_out                   // Poison levels
);
  logic [N_BANK-1:0] err_v, fix_v, def_v;
  logic              solo0;
  always_comb begin
    for (int i = 0; i < N_BANK; i++) begin
      err_v[i] = src_in[i].strobe && (src_in[i].actual != src_in[i].expected);
      fix_v[i] = err_v[i] && src_in[i].fixable;
      def_v[i] = err_v[i] && src_in[i].deferrable && !src_in[i].fixable;
    end
  end
  // Bank 0 acting alone, so its outcome is not masked by others
  assign solo0 = (err_v[N_BANK-1:1] == '0) && (consume_in == '0);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in || cold_rst_in);
  sequence s_err0;
    err_v[0] && solo0;
  endsequence
  a_apb_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out)
    else $error("ready not one wait state");
  a_rdy_has_req: assert property (pready_out |-> $past(psel_in && penable_in))
    else $error("ready without request");
  a_err_with_rdy: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_match_quiet: assert property (src_in[0].strobe && src_in[0].actual == src_in[0].expected && solo0
    |=> !machine_check_exception_out && !correct_out[0] && !contain_out[0])
    else $error("action on matching outcome");
  a_act_cause: assert property (correct_out[0] || contain_out[0] |-> $past(err_v[0]))
    else $error("action without error");
  a_corr_silent: assert property (correct_out[0] && $past(solo0) |-> !machine_check_exception_out)
    else $error("exception on corrected error");
  a_mce_cause: assert property (machine_check_exception_out |-> $past((|err_v) || (|consume_in)))
    else $error("exception without cause");
  a_defer_poison: assert property (s_err0 ##0 (src_in[0].deferrable && !src_in[0].fixable && !src_in[0].fatal)
    |=> poison_out[0] && !machine_check_exception_out)
    else $error("deferred error not poisoned");
  a_consume_clear: assert property (poison_out[0] && consume_in[0] && !err_v[0] |=> !poison_out[0])
    else $error("poison kept after consume");
  a_fatal_halts: assert property (s_err0 ##0 (src_in[0].fatal && !src_in[0].fixable && !src_in[0].deferrable)
    |=> shutdown_out)
    else $error("no shutdown on fatal error");
  a_halt_holds: assert property (shutdown_out |=> shutdown_out)
    else $error("shutdown dropped");
  a_dirq_cause: assert property (deferred_irq_out |-> $past(|def_v))
    else $error("deferred interrupt without cause");
  a_tirq_cause: assert property (threshold_irq_out |-> $past(|fix_v))
    else $error("threshold interrupt without cause");
endmodule
bind hel_top hel_props #(.N_BANK(N_BANK)) u_props (
  .clock_in(clock_in), .rst_in(rst_in), .cold_rst_in(cold_rst_in), .src_in(src_in),
  .consume_in(consume_in), .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .machine_check_exception_out(machine_check_exception_out),
  .shutdown_out(shutdown_out), .deferred_irq_out(deferred_irq_out), .threshold_irq_out(threshold_irq_out),
  .correct_out(correct_out), .contain_out(contain_out), .poison_out(poison_out));
`default_nettype wire

//--- hel_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module hel_core_model #(
  parameter int NB = 4
) (
  input  wire logic              clock_in,     // Core clock
  input  wire logic              mce_in,       // Exception pulse
  input  wire logic              dirq_in,      // Deferred interrupt
  input  wire logic              tirq_in,      // Threshold interrupt
  input  wire logic [NB-1:0]     corr_in,      // Correction pulses
  input  wire logic [NB-1:0]     cont_in,      // Containment pulses
  output var  hel_pkg::hel_src_t src_out [NB], // Source reports
  output var  logic [NB-1:0]     cons_out      // Consume pulses
);
  int n_mce = 0, n_dirq = 0, n_tirq = 0, n_corr = 0, n_cont = 0;
  initial begin
    cons_out = '0;
    for (int i = 0; i < NB; i++) src_out[i] = '0;
  end
  // Core side tallies every pulse it receives
  always @(posedge clock_in) begin
    n_mce <= n_mce + int'(mce_in);
    n_dirq <= n_dirq + int'(dirq_in);
    n_tirq <= n_tirq + int'(tirq_in);
    n_corr <= n_corr + $countones(corr_in);
    n_cont <= n_cont + $countones(cont_in);
  end
  // k: match, fixable, deferrable, fatal; qualifiers scrambled once strobe drops
  task automatic inject(input int b, input logic [3:0] k, input logic [31:0] a);
    @(posedge clock_in);
    src_out[b] <= '{1'b1, k[2], k[1], k[0], 8'h5A, k[3] ? 8'h5A : 8'hA5, a};
    @(posedge clock_in);
    src_out[b] <= '{1'b0, ~k[2], ~k[1], ~k[0], 8'hA5, 8'h3C, ~a};
  endtask
  task automatic consume(input int b);
    @(posedge clock_in);
    cons_out[b] <= 1'b1;
    @(posedge clock_in);
    cons_out[b] <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- test_hel_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_hel_top;
  localparam int NB = 4;
  hel_pkg::hel_src_t src [NB];
  logic [NB-1:0]     cons, corr, cont, poi;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, q;
  logic              clock_in, rst_in, cold_rst_in, psel, pen, pwr, prdy, perr, mce, shd, dirq, tirq, e;
  int                n_errors, n_compared;
  hel_top #(.N_BANK(NB)) uut (
    .clock_in(clock_in), .rst_in(rst_in), .cold_rst_in(cold_rst_in), .src_in(src), .consume_in(cons),
    .paddr_in(paddr), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(prdy), .pslverr_out(perr), .machine_check_exception_out(mce),
    .shutdown_out(shd), .deferred_irq_out(dirq), .threshold_irq_out(tirq), .correct_out(corr),
    .contain_out(cont), .poison_out(poi));
  hel_core_model #(.NB(NB)) m (
    .clock_in(clock_in), .mce_in(mce), .dirq_in(dirq), .tirq_in(tirq), .corr_in(corr),
    .cont_in(cont), .src_out(src), .cons_out(cons));
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    n_compared++;
    if (sn !== ex) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    pen <= 1'b1;
    do begin
      @(posedge clock_in);
      k++;
    end while (prdy !== 1'b1 && k < 20);
    if (k >= 20) cmp("pready", 1, prdy);
    q = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  function automatic logic [11:0] ba(input int b, input logic [11:0] o);
    return hel_pkg::OFS_BANK0 + hel_pkg::BANK_STRIDE * 12'(b) + o;
  endfunction
  task automatic chk(input logic [11:0] a, input logic [31:0] ex, input logic [31:0] mk);
    apb(1'b0, a, 32'h0000_0000);
    cmp($sformatf("read %h", a), ex, q & mk);
    cmp($sformatf("slverr %h", a), 0, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  // Negative expectation skips that tally
  task automatic ev(input int a, input int d, input int t, input int c, input int o);
    tick(1);
    if (a >= 0) cmp("mce count", a, m.n_mce);
    if (d >= 0) cmp("deferred irq count", d, m.n_dirq);
    if (t >= 0) cmp("threshold irq count", t, m.n_tirq);
    if (c >= 0) cmp("correct count", c, m.n_corr);
    if (o >= 0) cmp("contain count", o, m.n_cont);
  endtask
  initial begin
    #40000;
    n_errors++;
    results();
  end
  initial begin
    {rst_in, cold_rst_in, psel, pen, pwr, paddr, pwdata, n_errors, n_compared} = '0;
    rst_in = 1'b1;
    cold_rst_in = 1'b1;
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    cold_rst_in <= 1'b0;
    chk(hel_pkg::OFS_GCTL, 32'h0000_0000, 32'hFFFF_FFFF);
    chk(ba(0, hel_pkg::OFS_CTL), 32'h0000_0003, 32'hFFFF_FFFF);
    chk(ba(3, hel_pkg::OFS_MISC), 32'h0010_0000, 32'hFFFF_FFFF);
    apb(1'b0, 12'hFFC, 32'h0000_0000);
    cmp("unmapped slverr", 1, e);
    $display("test reset values done");
    m.inject(0, 4'b0000, 32'h1234_5678);
    ev(1, 0, 0, 0, 1);
    chk(ba(0, hel_pkg::OFS_STAT), 32'h8000_0003, 32'h8000_0003);
    chk(ba(0, hel_pkg::OFS_ADDR), 32'h1234_5678, 32'hFFFF_FFFF);
    m.inject(0, 4'b1000, 32'h0000_0040);
    ev(1, 0, 0, 0, 1);
    $display("test uncorrected done");
    apb(1'b1, ba(1, hel_pkg::OFS_CTL), 32'h0000_0001);
    m.inject(1, 4'b0000, 32'h0000_0100);
    ev(1, 0, 0, 0, 2);
    chk(ba(1, hel_pkg::OFS_STAT), 32'h8000_0003, 32'h8000_0003);
    apb(1'b1, ba(2, hel_pkg::OFS_CTL), 32'h0000_0002);
    m.inject(2, 4'b0000, 32'h0000_0200);
    ev(2, 0, 0, 0, 3);
    chk(ba(2, hel_pkg::OFS_STAT), 32'h0000_0000, 32'hFFFF_FFFF);
    $display("test enables done");
    apb(1'b1, hel_pkg::OFS_GCTL, 32'h0000_0003);
    apb(1'b1, ba(3, hel_pkg::OFS_MISC), 32'h0001_0000);
    m.inject(3, 4'b0100, 32'h0000_0300);
    ev(2, 0, 0, 1, 3);
    m.inject(3, 4'b0100, 32'h0000_0304);
    ev(2, 0, 1, 2, 3);
    m.inject(3, 4'b0100, 32'h0000_0308);
    ev(2, 0, 1, 3, 3);
    chk(ba(3, hel_pkg::OFS_MISC), 32'h0001_0003, 32'hFFFF_FFFF);
    chk(ba(3, hel_pkg::OFS_STAT), 32'h8000_0000, 32'h8000_0003);
    $display("test corrected done");
    apb(1'b1, ba(3, hel_pkg::OFS_CTL), 32'h0000_0007);
    m.inject(3, 4'b0100, 32'h0000_030C);
    ev(3, 0, 1, 3, 3);
    chk(ba(3, hel_pkg::OFS_STAT), 32'h0000_0003, 32'h0000_0003);
    $display("test action disable done");
    apb(1'b1, ba(1, hel_pkg::OFS_STAT), 32'h0000_0000);
    m.inject(1, 4'b0010, 32'h0000_0400);
    ev(3, 1, 1, 3, -1);
    cmp("poison 1", 1, poi[1]);
    chk(ba(1, hel_pkg::OFS_STAT), 32'h8000_0001, 32'h8000_0003);
    m.consume(1);
    ev(3, -1, 1, 3, -1);
    cmp("poison 1 consumed", 0, poi[1]);
    chk(ba(1, hel_pkg::OFS_STAT), 32'h0000_0003, 32'h0000_0003);
    m.inject(0, 4'b0010, 32'h0000_0500);
    ev(3, -1, 1, 3, -1);
    m.consume(0);
    ev(4, -1, 1, 3, -1);
    cmp("poison 0 consumed", 0, poi[0]);
    $display("test deferred done");
    m.inject(0, 4'b0001, 32'h0000_0600);
    tick(1);
    cmp("shutdown", 1, shd);
    chk(hel_pkg::OFS_GSTAT, 32'h0000_0001, 32'h0000_0001);
    $display("test shutdown done");
    @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    #1;
    cmp("shutdown after reset", 0, shd);
    chk(ba(1, hel_pkg::OFS_STAT), 32'h8000_0003, 32'h8000_0003);
    chk(ba(1, hel_pkg::OFS_CTL), 32'h0000_0003, 32'hFFFF_FFFF);
    @(posedge clock_in);
    cold_rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    cold_rst_in <= 1'b0;
    chk(ba(1, hel_pkg::OFS_STAT), 32'h0000_0000, 32'hFFFF_FFFF);
    $display("test resets done");
    results();
  end
endmodule
`default_nettype wire
